/* pkg/idx_pkg.sv */
package idx_pkg;
   // instruction classes handled by this block
   typedef enum logic [2:0] {
      op_none,
      op_decrement,
      op_increment,
      op_increment_skip_zero,
      op_interrupt_off,
      op_interrupt_on,
      op_computed_jump
   } idx_op_type;

   // register map (byte addresses)
   localparam logic [11:0] IDX_ADDR_CMD    = 12'h0000;
   localparam logic [11:0] IDX_ADDR_OPND   = 12'h0004;
   localparam logic [11:0] IDX_ADDR_ACC    = 12'h0008;
   localparam logic [11:0] IDX_ADDR_TBH    = 12'h000c;
   localparam logic [11:0] IDX_ADDR_STATUS = 12'h0010;
   localparam logic [11:0] IDX_ADDR_PC     = 12'h0014;
   localparam logic [11:0] IDX_ADDR_FILE   = 12'h0200;

   // field positions
   localparam int IDX_CMD_OP_LSB   = 0;
   localparam int IDX_CMD_DEST_BIT = 4;
   localparam int IDX_ST_ZERO      = 0;
   localparam int IDX_ST_GIE       = 1;
   localparam int IDX_ST_BUSY      = 2;
   localparam int IDX_ST_SKIP      = 3;

   // widths and reset values
   localparam int          IDX_FILE_DEPTH = 128;
   localparam int          IDX_PC_W       = 11;
   localparam int          IDX_TBH_W      = 3;
   localparam logic [7:0]  IDX_BYTE_ONE   = 8'h01;
   localparam logic [7:0]  IDX_BYTE_ZERO  = 8'h00;
   localparam logic [10:0] IDX_PC_RESET   = 11'h000;

   // cycles per instruction
   localparam int IDX_CYC_SHORT = 1;
   localparam int IDX_CYC_LONG  = 2;
endpackage : idx_pkg

/* pkg/idx_exec_if.sv */
`timescale 1ns/10ps
interface idx_exec_if;
   import idx_pkg::*;
   logic       start;
   idx_op_type op;
   logic [7:0] operand;
   logic [7:0] acc_in;
   logic [2:0] tbh_in;
   logic [7:0] result;
   logic       zero;
   logic       skip;
   logic [1:0] cycles;
   logic [10:0] target;
   modport core (output start, op, operand, acc_in, tbh_in,
                 input result, zero, skip, cycles, target);
   modport alu  (input start, op, operand, acc_in, tbh_in,
                 output result, zero, skip, cycles, target);
endinterface : idx_exec_if

/* core/idx_alu.sv */
`timescale 1ns/10ps
module idx_alu
   import idx_pkg::*;
(
   idx_exec_if.alu ex
);
   wire is_dec = (ex.op == op_decrement);
   wire is_inc = (ex.op == op_increment) || (ex.op == op_increment_skip_zero);
   wire is_jmp = (ex.op == op_computed_jump);

   // arithmetic result
   assign ex.result = is_dec ? 8'(ex.operand - IDX_BYTE_ONE) :
                      is_inc ? 8'(ex.operand + IDX_BYTE_ONE) :
                      ex.acc_in;
   assign ex.zero   = (ex.result == IDX_BYTE_ZERO);
   assign ex.skip   = ex.start && (ex.op == op_increment_skip_zero) && ex.zero;
   assign ex.cycles = (ex.skip || is_jmp) ? 2'(IDX_CYC_LONG)
                                          : 2'(IDX_CYC_SHORT);
   assign ex.target = {ex.tbh_in, ex.acc_in};
endmodule : idx_alu

/* core/idx_core.sv */
`timescale 1ns/10ps
module idx_core
   import idx_pkg::*;
#(
   parameter int DEPTH = IDX_FILE_DEPTH
)(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // core state
   output logic             global_irq_enable,
   output logic [10:0]      pc_out,
   output logic             skip_next
);
   idx_exec_if ex ();
   idx_alu u_alu (.ex(ex));

   logic [7:0]  file_mem [DEPTH];
   logic [7:0]  accumulator;
   logic [2:0]  table_high_pointer;
   logic [10:0] pc;
   logic        zero_flag;
   logic [6:0]  cmd_addr;
   logic        busy;
   logic [1:0]  cyc_left;
   logic        skip_flag;
   logic        dp_write;
   logic [11:0] dp_addr;

   // file window decode shared by the write and read paths
   function automatic logic in_file_window(input logic [11:0] a);
      return (a >= IDX_ADDR_FILE) && (a < IDX_ADDR_FILE + 12'(DEPTH * 4));
   endfunction : in_file_window

   function automatic logic [6:0] file_slot(input logic [11:0] a);
      return 7'((a - IDX_ADDR_FILE) >> 2);
   endfunction : file_slot

   // ahb address phase capture
   wire        take      = hsel && hready && htrans[1];
   wire        wr_strobe = dp_write;
   wire [11:0] wa        = dp_addr;
   wire        in_file   = in_file_window(wa);
   wire [6:0]  file_idx  = file_slot(wa);
   wire        cmd_wr    = wr_strobe && (wa == IDX_ADDR_CMD) && !busy;

   // register write strobes from the bus
   wire        sw_opnd   = wr_strobe && (wa == IDX_ADDR_OPND);
   wire        sw_acc    = wr_strobe && (wa == IDX_ADDR_ACC);
   wire        sw_tbh    = wr_strobe && (wa == IDX_ADDR_TBH);
   wire        sw_file   = wr_strobe && in_file;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dp_write <= 1'b0;
         dp_addr  <= 12'h000;
      end else begin
         dp_write <= take && hwrite;
         dp_addr  <= take ? haddr[11:0] : dp_addr;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // decoded instruction presented to the alu
   wire idx_op_type dec_op = idx_op_type'(hwdata[IDX_CMD_OP_LSB +: 3]);
   assign ex.start   = cmd_wr;
   assign ex.op      = dec_op;
   assign ex.operand = file_mem[cmd_addr];
   assign ex.acc_in  = accumulator;
   assign ex.tbh_in  = table_high_pointer;

   wire dest_reg  = hwdata[IDX_CMD_DEST_BIT];
   wire is_arith  = (dec_op == op_decrement) || (dec_op == op_increment) ||
                    (dec_op == op_increment_skip_zero);
   wire upd_zero  = (dec_op == op_decrement) || (dec_op == op_increment);
   wire wr_acc    = cmd_wr && is_arith && !dest_reg;
   wire wr_file   = cmd_wr && is_arith && dest_reg;
   wire [10:0] jump_target = ex.target;

   // operand register and software-loaded state
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_addr <= 7'h00;
      end else if (sw_opnd) begin
         cmd_addr <= hwdata[6:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         accumulator <= IDX_BYTE_ZERO;
      end else if (wr_acc) begin
         accumulator <= ex.result;
      end else if (sw_acc) begin
         accumulator <= hwdata[7:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         table_high_pointer <= 3'h0;
      end else if (sw_tbh) begin
         table_high_pointer <= hwdata[2:0];
      end
   end

   // file registers
   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++) begin : g_file
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               file_mem[gi] <= IDX_BYTE_ZERO;
            end else if (wr_file && cmd_addr == 7'(gi)) begin
               file_mem[gi] <= ex.result;
            end else if (sw_file && file_idx == 7'(gi)) begin
               file_mem[gi] <= hwdata[7:0];
            end
         end
      end
   endgenerate

   // flags
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         zero_flag         <= 1'b0;
         global_irq_enable <= 1'b0;
      end else if (cmd_wr) begin
         if (upd_zero) begin
            zero_flag <= ex.zero;
         end
         if (dec_op == op_interrupt_off) begin
            global_irq_enable <= 1'b0;
         end else if (dec_op == op_interrupt_on) begin
            global_irq_enable <= 1'b1;
         end
      end
   end

   // program counter and cycle accounting
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pc <= IDX_PC_RESET;
      end else if (cmd_wr && dec_op == op_computed_jump) begin
         pc <= jump_target;
      end else if (cmd_wr && ex.skip) begin
         pc <= 11'(pc + 11'h002);
      end else if (cmd_wr && dec_op != op_none) begin
         pc <= 11'(pc + 11'h001);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cyc_left  <= 2'b00;
         skip_flag <= 1'b0;
      end else if (cmd_wr) begin
         cyc_left  <= 2'(ex.cycles - 2'd1);
         skip_flag <= ex.skip;
      end else if (cyc_left != 2'b00) begin
         cyc_left  <= 2'(cyc_left - 2'd1);
      end
   end

   assign busy      = (cyc_left != 2'b00);
   assign pc_out    = pc;
   assign skip_next = skip_flag;

   // read mux
   logic [11:0] ra;
   logic        rd_take;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ra      <= 12'h000;
         rd_take <= 1'b0;
      end else begin
         ra      <= haddr[11:0];
         rd_take <= take && !hwrite;
      end
   end

   wire        r_file = in_file_window(ra);
   wire [6:0]  r_idx  = file_slot(ra);

   // status word assembled from the named field positions
   logic [31:0] st_word;
   always_comb begin
      st_word              = 32'h0000_0000;
      st_word[IDX_ST_ZERO] = zero_flag;
      st_word[IDX_ST_GIE]  = global_irq_enable;
      st_word[IDX_ST_BUSY] = busy;
      st_word[IDX_ST_SKIP] = skip_flag;
   end
   wire [31:0] rd_mux =
      !rd_take                 ? 32'h0000_0000 :
      (ra == IDX_ADDR_OPND)    ? {25'h000_0000, cmd_addr} :
      (ra == IDX_ADDR_ACC)     ? {24'h00_0000, accumulator} :
      (ra == IDX_ADDR_TBH)     ? {29'h0000_0000, table_high_pointer} :
      (ra == IDX_ADDR_STATUS)  ? st_word :
      (ra == IDX_ADDR_PC)      ? {21'h00_0000, pc} :
      r_file                   ? {24'h00_0000, file_mem[r_idx]} :
                                 32'h0000_0000;
   assign hrdata = rd_mux;
endmodule : idx_core

/* bench/idx_core_assertions.sv */
`timescale 1ns/10ps
module idx_core_assertions
   import idx_pkg::*;
(
   // clock, reset
   input wire logic        sys_clk,
   input wire logic        rst_n,
   // bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hwdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // core state
   input wire logic        global_irq_enable,
   input wire logic [10:0] pc_out,
   input wire logic        skip_next
);
   logic            cmd_ph;
   wire logic       cmd_hit = hsel && hready && htrans[1] && hwrite
                              && haddr == {20'h0, IDX_ADDR_CMD};
   wire logic [2:0] op = hwdata[2:0];
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n) cmd_ph <= 1'b0;
      else cmd_ph <= cmd_hit;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_cmd(logic [2:0] o); cmd_ph && op == o; endsequence
   sequence s_one; s_cmd(3'h1) or s_cmd(3'h2) or s_cmd(3'h4) or s_cmd(3'h5); endsequence
   property p_irq_off; s_cmd(3'h4) |=> !global_irq_enable; endproperty
   a_irq_off: assert property (p_irq_off) else $error("enable not cleared");
   property p_irq_on; s_cmd(3'h5) |=> global_irq_enable; endproperty
   a_irq_on: assert property (p_irq_on) else $error("enable not set");
   property p_gie_hold;
      !(cmd_ph && op inside {3'h4, 3'h5}) |=> $stable(global_irq_enable);
   endproperty
   a_gie_hold: assert property (p_gie_hold) else $error("enable moved");
   property p_pc_step; s_one |=> pc_out == $past(pc_out) + 11'h001; endproperty
   a_pc_step: assert property (p_pc_step) else $error("pc step wrong");
   property p_skip_pc;
      s_cmd(3'h3) |=> pc_out == $past(pc_out) + (skip_next ? 11'h002 : 11'h001);
   endproperty
   a_skip_pc: assert property (p_skip_pc) else $error("skip pc wrong");
   property p_no_skip; (s_cmd(3'h1) or s_cmd(3'h2) or s_cmd(3'h6)) |=> !skip_next; endproperty
   a_no_skip: assert property (p_no_skip) else $error("skip flag set");
   property p_jump_hold; s_cmd(3'h6) |=> ##1 $stable(pc_out); endproperty
   a_jump_hold: assert property (p_jump_hold) else $error("jump pc moved");
   property p_bus_ok; hreadyout && !hresp; endproperty
   a_bus_ok: assert property (p_bus_ok) else $error("bus not ready or error");
endmodule : idx_core_assertions
bind idx_core idx_core_assertions u_chk (.sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
   .hready, .hwdata, .hreadyout, .hresp, .global_irq_enable, .pc_out, .skip_next);

/* bench/incdec_branch_int_exec_tb.sv */
`timescale 1ns/10ps
module incdec_branch_int_exec_tb;
   import idx_pkg::*;
   logic        sys_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2, ftbh = 3'h0;
   logic        hreadyout, hresp, global_irq_enable, skip_next, fz = 1'b0, fg = 1'b0, fs;
   logic [10:0] pc_out, fpc = 11'h000;
   logic [7:0]  facc = 8'h00, ffile[128];
   wire logic   hready = hreadyout;
   int          num_errors = 0, n_tests = 0, seed = 58765;
   string       names[$];
   logic [31:0] exps[$];
   idx_core dut (.sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata,
      .hrdata, .hreadyout, .hresp, .global_irq_enable, .pc_out, .skip_next);
   always #10 sys_clk = ~sys_clk;
   function automatic logic [11:0] fa(input logic [6:0] n);
      return IDX_ADDR_FILE + {3'h0, n, 2'h0};
   endfunction : fa
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : final_report
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge sys_clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {20'h0, a};
      hwrite <= w;
      do @(posedge sys_clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge sys_clk); while (hready !== 1'b1);
   endtask : bus
   task automatic expect_rd(input string nm, input logic [11:0] a, input logic [31:0] v);
      names.push_back(nm);
      exps.push_back(v);
      bus(1'b0, a, 32'h0);
   endtask : expect_rd
   task automatic run(input logic [2:0] op, input logic dst, input logic [6:0] n,
                      input logic [7:0] v);
      logic [7:0] r;
      bus(1'b1, fa(n), {24'h0, v});
      ffile[n] = v;
      bus(1'b1, IDX_ADDR_OPND, {25'h0, n});
      bus(1'b1, IDX_ADDR_CMD, {24'h0, 3'h0, dst, 1'b0, op});
      r  = (op == 3'h1) ? v - 8'h01 : v + 8'h01;
      fs = (op == 3'h3) && (r == 8'h00);
      if (op != 3'h0 && op < 3'h4 && dst) ffile[n] = r;
      if (op != 3'h0 && op < 3'h4 && !dst) facc = r;
      if (op != 3'h0 && op < 3'h3) fz = (r == 8'h00);
      if (op == 3'h4 || op == 3'h5) fg = op[0];
      if (op == 3'h6) fpc = {ftbh, facc};
      else if (op != 3'h0) fpc = fpc + (fs ? 11'h002 : 11'h001);
      expect_rd("file", fa(n), {24'h0, ffile[n]});
      expect_rd("acc", IDX_ADDR_ACC, {24'h0, facc});
      expect_rd("st", IDX_ADDR_STATUS,
                {28'h0, fs, 1'b0, fg, fz});
      expect_rd("pc", IDX_ADDR_PC, {21'h0, fpc});
   endtask : run
   always @(posedge sys_clk) begin
      if (rd_ph && hready) check(names.pop_front(), hrdata, exps.pop_front());
      if (hready) rd_ph <= hsel && htrans[1] && !hwrite;
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      num_errors++;
      final_report();
   end
   initial begin
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      expect_rd("st", IDX_ADDR_STATUS, 32'h0);
      for (int i = 0; i < 12; i++) begin
         d = $random(seed);
         if (i >= 6) d[7:0] = (i % 3 == 0) ? 8'h01 : 8'hff;
         run(3'(i % 3 + 1), 1'((i / 3) % 2), d[14:8], d[7:0]);
      end
      run(3'h0, 1'b1, 7'h03, 8'hff);
      run(3'h5, 1'b0, 7'h7f, 8'h00);
      run(3'h4, 1'b1, 7'h00, 8'h00);
      run(3'h5, 1'b0, 7'h01, 8'h00);
      d = $random(seed);
      bus(1'b1, IDX_ADDR_ACC, d);
      bus(1'b1, IDX_ADDR_TBH, {d[7:0], d[31:8]});
      facc = d[7:0];
      ftbh = d[10:8];
      run(3'h6, 1'b0, 7'h02, 8'h00);
      bus(1'b1, IDX_ADDR_PC, d);
      expect_rd("pc", IDX_ADDR_PC, {21'h0, fpc});
      expect_rd("unmapped", 12'h100, 32'h0);
      repeat (3) @(posedge sys_clk);
      final_report();
   end
endmodule : incdec_branch_int_exec_tb
